// ---- dv/nand_dev_model.sv ----
// Behavioural NAND device answering page reads and column jumps
`timescale 1ns/1ps

module nand_dev_model (
	input  wire        i_ce_n,
	input  wire        i_cle,
	input  wire        i_ale,
	input  wire        i_we_n,
	input  wire        i_re_n,
	input  wire        i_wp_n,
	input  wire        i_pt,
	input  wire [7:0]  i_io,
	input  wire [31:0] i_busy_ns,
	output reg  [7:0]  o_io,
	output reg         o_rb
);
	reg [7:0]  ab [0:4];
	reg [2:0]  an;
	reg [2:0]  last_an;
	reg [11:0] col;
	reg [17:0] row;
	reg [11:0] ptr;
	reg        plane;
	reg        locked;
	initial begin
		o_io = 8'h5a;
		o_rb = 1'b1;
		an = 3'h0;
		ptr = 12'h000;
		// Sampled after the host's reset has set its pins
		#20 locked = i_pt;
	end
	// ----------------------------------------
	// Command and address capture
	// ----------------------------------------
	// Only reads are modelled, so no program or erase can start here
	always @(posedge i_we_n) begin
		if (!i_ce_n && i_ale && an < 3'h5) begin
			ab[an] = i_io;
			an = an + 3'h1;
		end
		if (!i_ce_n && i_cle) begin
			if (i_io == 8'h30 && an == 3'h5) begin
				col = {ab[1][3:0], ab[0]};
				row = {ab[4][1:0], ab[3], ab[2]};
				plane = ab[2][6];
				ptr = col;
				// Busy ignores chip enable, so host toggling cannot cut it short
				o_rb <= #50 1'b0;
				o_rb <= #(50 + i_busy_ns) 1'b1;
			end
			if (i_io == 8'he0 && an == 3'h2) begin
				ptr = {ab[1][3:0], ab[0]};
			end
			// Address cycles seen since the previous command
			last_an = an;
			an = 3'h0;
		end
	end
	// ----------------------------------------
	// Data out
	// ----------------------------------------
	always @(negedge i_re_n) begin
		if (!i_ce_n && o_rb) begin
			o_io <= #15 row[7:0] ^ ptr[7:0] ^ {ptr[11:8], ptr[11:8]};
			ptr = ptr + 12'h001;
		end
	end
	// Released bus must not keep showing the last byte
	always @(posedge i_ce_n) begin
		o_io <= #5 ~o_io;
	end
endmodule // nand_dev_model

// ---- dv/nand_read_host_monitor.sv ----
// Port checker for the NAND page read host
`timescale 1ns/1ps

module nand_read_host_monitor (
	input wire       i_clk_sys,
	input wire       i_reset_n,
	input wire       i_start_page_read,
	input wire       i_edo_mode,
	input wire       i_ready_busy,
	input wire       o_busy,
	input wire       o_done,
	input wire       o_timeout,
	input wire       o_ce_n,
	input wire       o_cle,
	input wire       o_ale,
	input wire       o_we_n,
	input wire       o_read_strobe_n,
	input wire       o_wp_n,
	input wire       o_powerup_protect_in,
	input wire [7:0] o_io_bus,
	input wire       o_io_bus_oe
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	reg [15:0] low_cnt;
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			low_cnt <= 16'h0000;
		end else begin
			low_cnt <= i_ready_busy ? 16'h0000 : low_cnt + 16'h0001;
		end
	end
	sequence s_strobe_tail;
		!o_we_n ##1 o_we_n;
	endsequence
	property p_we_low_two;
		$fell(o_we_n) |=> s_strobe_tail;
	endproperty
	a_we_low_two: assert property (p_we_low_two) else $error("write strobe width wrong");
	property p_latch_held;
		$rose(o_we_n) && (o_cle || o_ale) |-> o_io_bus_oe && $stable(o_io_bus) && $past(o_io_bus, 2) == o_io_bus;
	endproperty
	a_latch_held: assert property (p_latch_held) else $error("bus byte moved under write strobe");
	property p_excl;
		!(o_cle && o_ale);
	endproperty
	a_excl: assert property (p_excl) else $error("both latch enables high");
	property p_wp;
		!o_wp_n && !o_powerup_protect_in;
	endproperty
	a_wp: assert property (p_wp) else $error("protect pins not low");
	property p_start_busy;
		i_start_page_read && !o_busy && !o_done |=> o_busy;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start not taken");
	property p_done_pulse;
		o_done |=> !o_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
	property p_read_ready;
		$fell(o_read_strobe_n) |-> $past(i_ready_busy) && i_ready_busy;
	endproperty
	a_read_ready: assert property (p_read_ready) else $error("read strobe while busy");
	property p_read_bus;
		!o_read_strobe_n |-> !o_ce_n && !o_io_bus_oe;
	endproperty
	a_read_bus: assert property (p_read_bus) else $error("read strobe with bus driven");
	property p_edo_width;
		$fell(o_read_strobe_n) && i_edo_mode |=> o_read_strobe_n;
	endproperty
	a_edo_width: assert property (p_edo_width) else $error("fast read strobe too long");
	property p_timeout;
		$rose(o_timeout) |-> low_cnt >= 16'h0960 && low_cnt <= 16'h0a28;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout at wrong count");
endmodule // nand_read_host_monitor

bind nand_read_host nand_read_host_monitor mon_u (.i_clk_sys, .i_reset_n, .i_start_page_read, .i_edo_mode,
	.i_ready_busy, .o_busy, .o_done, .o_timeout, .o_ce_n, .o_cle, .o_ale, .o_we_n, .o_read_strobe_n, .o_wp_n,
	.o_powerup_protect_in, .o_io_bus, .o_io_bus_oe);

// ---- dv/nand_read_host_tb.sv ----
// Self-checking bench for the NAND page read host
`timescale 1ns/1ps

module nand_read_host_tb;
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg         st_rd = 1'b0;
	reg         st_jmp = 1'b0;
	reg  [11:0] col_in = 12'h000;
	reg  [17:0] row_in = 18'h00000;
	reg  [11:0] cnt_in = 12'h000;
	reg         extended_data_out = 1'b0;
	reg         rdy = 1'b0;
	reg         rdy_on = 1'b0;
	reg  [31:0] busy_ns = 32'h00000bb8;
	wire [7:0]  dat, h_io, d_io, io_w;
	wire        dv, bsy, dn, tmo, ce_n, cle, ale, we_n, re_n, wp_n, pt, oe, rb;
	reg  [7:0]  got [$];
	reg  [7:0]  exp_q [$];
	reg  [17:0] last_row;
	integer     mismatches = 0;
	integer     n_compared = 0;
	integer     cyc = 0;
	assign io_w = oe ? h_io : d_io;
	always #5 clk = ~clk;
	nand_read_host dut_u (.i_clk_sys(clk), .i_reset_n(rst_n), .i_start_page_read(st_rd), .i_start_column_jump(st_jmp),
		.i_column(col_in), .i_row(row_in), .i_byte_count(cnt_in), .i_edo_mode(extended_data_out), .o_data(dat),
		.o_data_valid(dv), .i_data_ready(rdy), .o_busy(bsy), .o_done(dn), .o_timeout(tmo), .o_ce_n(ce_n),
		.o_cle(cle), .o_ale(ale), .o_we_n(we_n), .o_read_strobe_n(re_n), .o_wp_n(wp_n),
		.o_powerup_protect_in(pt), .i_io_bus(io_w), .o_io_bus(h_io), .o_io_bus_oe(oe), .i_ready_busy(rb));
	nand_dev_model dev_u (.i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n), .i_wp_n(wp_n),
		.i_pt(pt), .i_io(io_w), .i_busy_ns(busy_ns), .o_io(d_io), .o_rb(rb));
	task test_done;
		begin
			if (mismatches == 0 && n_compared > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			n_compared++;
			if (g !== e) begin
				mismatches++;
				$display("MISMATCH %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk);
	endtask
	// ----------------------------------------
	// Consumer and hang guard
	// ----------------------------------------
	always @(posedge clk) begin
		if (dv === 1'b1 && rdy === 1'b1)
			got.push_back(dat);
		rdy <= rdy_on ? 1'($urandom_range(1, 0)) : 1'b0;
		cyc = cyc + 1;
		if (cyc == 80000) begin
			mismatches++;
			test_done();
		end
	end
	// One operation: expected bytes follow the column from the start point
	task run(input jmp, input [11:0] c, input [17:0] r, input [11:0] n, input e, input stall, input to);
		integer k, want, w;
		reg [11:0] p;
		begin
			want = to ? 0 : ((n < 2112 - c) ? n : 2112 - c);
			if (!jmp)
				last_row = r;
			// Column carries into its upper nibble, as the device counter does
			for (k = 0; k < want; k++) begin
				p = c + k[11:0];
				exp_q.push_back(last_row[7:0] ^ p[7:0] ^ {p[11:8], p[11:8]});
			end
			got.delete();
			@(posedge clk);
			rdy_on <= !stall;
			col_in <= c;
			row_in <= r;
			cnt_in <= n;
			extended_data_out <= e;
			st_rd <= !jmp;
			st_jmp <= jmp;
			@(posedge clk);
			st_rd <= 1'b0;
			st_jmp <= 1'b0;
			if (stall) begin
				tick(800);
				chk("stalled", 1, dv === 1'b1 && dev_u.ptr - c <= 32 && got.size() == 0);
				rdy_on <= 1'b1;
			end
			for (w = 0; w < 6000 && dn !== 1'b1; w++)
				@(posedge clk);
			chk("timeout", to, tmo);
			chk("addr_cycles", jmp ? 2 : 5, dev_u.last_an);
			if (!jmp && !to) begin
				chk("column", c, dev_u.col);
				chk("row", r, dev_u.row);
				chk("plane", r[6], dev_u.plane);
				chk("col_hi_zero", 0, dev_u.ab[1][7:4]);
				chk("row_top_zero", 0, dev_u.ab[4][7:2]);
			end
			for (w = 0; w < 600 && got.size() < want; w++)
				@(posedge clk);
			tick(20);
			chk("count", want, got.size());
			for (k = 0; k < want && k < got.size(); k++)
				chk("byte", exp_q[k], got[k]);
			exp_q.delete();
		end
	endtask
	initial begin
		void'($urandom(32'h50d4802a));
		tick(10);
		rst_n <= 1'b1;
		tick(2);
		chk("protect_off", 0, dev_u.locked);
		// A jump before any page is loaded is refused
		st_jmp <= 1'b1;
		tick(1);
		st_jmp <= 1'b0;
		tick(20);
		chk("jump_refused", 0, bsy);
		run(0, 12'h000, 18'h30040, 12'h010, 0, 0, 0);
		run(0, 12'h834, 18'h0a5c3, 12'h014, 1, 0, 0);
		run(1, 12'h005, 18'h00000, 12'h008, 1, 0, 0);
		run(1, 12'h83f, 18'h00000, 12'h004, 0, 0, 0);
		run(0, 12'($urandom_range(2000, 0)), 18'($urandom), 12'h028, 0, 1, 0);
		run(0, 12'h7ff, 18'h12345, 12'h000, 0, 0, 0);
		busy_ns = 32'h00007530;
		run(0, 12'h010, 18'h00001, 12'h008, 0, 0, 1);
		tick(800);
		busy_ns = 32'h00000bb8;
		run(0, 12'h020, 18'h00002, 12'h008, 1, 0, 0);
		test_done();
	end
endmodule // nand_read_host_tb

// ---- hw/nand_read_host.v ----
// Host controller driving a NAND flash for page read and column jump
//
// Function
// - Host holds write protect low through power-up and power-down.
// - A full address is five cycles: two column then three row.
// - Column cycles carry bits 0-7, then bits 8-11 with upper lines low.
// - Row cycles carry 12-19, 20-27, then 28 and 29 only, rest low.
// - Page read is 00h, five address cycles, 30h, then busy.
// - Host reads data only after ready/busy returns ready.
// - Below 30ns read period, host samples data at the following strobe fall.
// - Column jump is 05h, two column cycles, E0h, then data from that column.
`timescale 1ns/1ps
`include "nand_host_defs.vh"

module nand_read_host (
	input  wire        i_clk_sys,
	input  wire        i_reset_n,
	input  wire        i_start_page_read,
	input  wire        i_start_column_jump,
	input  wire [11:0] i_column,
	input  wire [17:0] i_row,
	input  wire [11:0] i_byte_count,
	input  wire        i_edo_mode,
	output wire [7:0]  o_data,
	output wire        o_data_valid,
	input  wire        i_data_ready,
	output reg         o_busy,
	output reg         o_done,
	output reg         o_timeout,
	output reg         o_ce_n,
	output reg         o_cle,
	output reg         o_ale,
	output reg         o_we_n,
	output reg         o_read_strobe_n,
	output reg         o_wp_n,
	output reg         o_powerup_protect_in,
	input  wire [7:0]  i_io_bus,
	output reg  [7:0]  o_io_bus,
	output reg         o_io_bus_oe,
	input  wire        i_ready_busy
);

	// ----------------------------------------
	// States and local constants
	// ----------------------------------------
	localparam S_IDLE     = 3'd0;
	localparam S_SETUP    = 3'd1;
	localparam S_WE_LOW   = 3'd2;
	localparam S_WE_HIGH  = 3'd3;
	localparam S_WAIT_WB  = 3'd4;
	localparam S_WAIT_RDY = 3'd5;
	localparam S_READ     = 3'd6;
	localparam S_FINISH   = 3'd7;

	localparam CAP_DLY   = `CAPTURE_DELAY;
	localparam [5:0] ROOM_LIMIT = `FIFO_DEPTH - `CAPTURE_DELAY;
	localparam [11:0] WE_LOW_T   = `WE_LOW_CYC - 1;
	localparam [11:0] WE_HIGH_T  = `WE_HIGH_CYC - 1;
	localparam [11:0] WB_T       = `WB_DELAY_CYC - 1;
	localparam [11:0] ARRAY_T    = `ARRAY_READ_CYC;
	localparam [11:0] RE_LOW_T   = `RE_LOW_CYC - 1;
	localparam [11:0] RE_HIGH_T  = `RE_HIGH_CYC - 1;
	localparam [11:0] RE_LOW_ET  = `RE_LOW_EDO_CYC - 1;
	localparam [11:0] RE_HIGH_ET = `RE_HIGH_EDO_CYC - 1;
	localparam [2:0]  READ_LAST  = `READ_ADDR_CYCLES + 3'h1;
	localparam [2:0]  JUMP_LAST  = `JUMP_ADDR_CYCLES + 3'h1;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [7:0] io_meta;
	reg [7:0] io_sync;
	reg       rb_meta;
	reg       rb_sync;

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			io_meta <= 8'h00;
			io_sync <= 8'h00;
			rb_meta <= 1'b0;
			rb_sync <= 1'b0;
		end else begin
			io_meta <= i_io_bus;
			io_sync <= io_meta;
			rb_meta <= i_ready_busy;
			rb_sync <= rb_meta;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	reg [2:0]         state;
	reg [11:0]        timer;
	reg               jump_op;
	reg [2:0]         seq_idx;
	reg [11:0]        column;
	reg [17:0]        row;
	reg [12:0]        falls_left;
	reg [CAP_DLY-1:0] cap_pipe;
	reg               extended_data_out;
	reg               page_loaded;

	wire       fifo_in_ready;
	wire [5:0] fifo_count;
	wire       cap_now = (state == S_READ) && cap_pipe[CAP_DLY-1];

	// ----------------------------------------
	// Bus cycle sequence
	// ----------------------------------------
	reg [7:0] seq_byte;
	reg       seq_cmd;
	reg [2:0] seq_last;

	always @* begin
		seq_cmd  = 1'b0;
		seq_byte = 8'h00;
		seq_last = jump_op ? JUMP_LAST : READ_LAST;
		case (seq_idx)
			3'd0: begin
				seq_cmd  = 1'b1;
				seq_byte = jump_op ? `CMD_JUMP_SETUP : `CMD_READ_SETUP;
			end
			3'd1: seq_byte = column[7:0];
			3'd2: seq_byte = {4'h0, column[11:8]};
			3'd3: begin
				if (jump_op) begin
					seq_cmd  = 1'b1;
					seq_byte = `CMD_JUMP_CONFIRM;
				end else begin
					// Bit 6 of this byte is the plane select
					seq_byte = row[7:0];
				end
			end
			3'd4: seq_byte = row[15:8];
			3'd5: seq_byte = {6'h00, row[`ROW_TOP_BIT_LSB] & `DENSITY_4GB, row[16]};
			3'd6: begin
				seq_cmd  = 1'b1;
				seq_byte = `CMD_READ_CONFIRM;
			end
			default: seq_byte = 8'h00;
		endcase
	end

	// Clip the transfer at the end of main plus spare area
	wire [12:0] room_in_page = (i_column >= `PAGE_BYTES) ? 13'h0000 : (`PAGE_BYTES - {1'b0, i_column});
	wire [12:0] want         = {1'b0, i_byte_count};
	wire [12:0] clipped      = (want > room_in_page) ? room_in_page : want;
	wire        may_fall     = (falls_left != 13'h0000) && (fifo_count <= ROOM_LIMIT) && fifo_in_ready;

	// ----------------------------------------
	// Main sequencer
	// ----------------------------------------
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state                <= S_IDLE;
			timer                <= 12'h000;
			jump_op              <= 1'b0;
			seq_idx              <= 3'h0;
			column               <= 12'h000;
			row                  <= 18'h00000;
			falls_left           <= 13'h0000;
			cap_pipe             <= {CAP_DLY{1'b0}};
			extended_data_out                  <= 1'b0;
			page_loaded          <= 1'b0;
			o_busy               <= 1'b0;
			o_done               <= 1'b0;
			o_timeout            <= 1'b0;
			o_ce_n               <= 1'b1;
			o_cle                <= 1'b0;
			o_ale                <= 1'b0;
			o_we_n               <= 1'b1;
			o_read_strobe_n      <= 1'b1;
			o_wp_n               <= 1'b0;
			o_powerup_protect_in <= 1'b0;
			o_io_bus             <= 8'h00;
			o_io_bus_oe          <= 1'b0;
		end else begin
			o_done   <= 1'b0;
			cap_pipe <= {cap_pipe[CAP_DLY-2:0], 1'b0};
			case (state)
				S_IDLE: begin
					o_ce_n <= 1'b1;
					if (i_start_page_read || (i_start_column_jump && page_loaded)) begin
						jump_op    <= !i_start_page_read;
						column     <= i_column;
						row        <= i_start_page_read ? i_row : row;
						falls_left <= clipped;
						extended_data_out        <= i_edo_mode;
						seq_idx    <= 3'h0;
						o_busy     <= 1'b1;
						o_timeout  <= 1'b0;
						o_ce_n     <= 1'b0;
						state      <= S_SETUP;
					end
				end
				S_SETUP: begin
					o_cle       <= seq_cmd;
					o_ale       <= !seq_cmd;
					o_io_bus    <= seq_byte;
					o_io_bus_oe <= 1'b1;
					o_we_n      <= 1'b0;
					timer       <= WE_LOW_T;
					state       <= S_WE_LOW;
				end
				S_WE_LOW: begin
					if (timer == 12'h000) begin
						// Rising write strobe latches command or address
						o_we_n <= 1'b1;
						timer  <= WE_HIGH_T;
						state  <= S_WE_HIGH;
					end else begin
						timer <= timer - 12'h001;
					end
				end
				S_WE_HIGH: begin
					if (timer == 12'h000) begin
						o_cle       <= 1'b0;
						o_ale       <= 1'b0;
						o_io_bus_oe <= 1'b0;
						if (seq_idx == seq_last) begin
							timer <= WB_T;
							state <= S_WAIT_WB;
						end else begin
							seq_idx <= seq_idx + 3'h1;
							state   <= S_SETUP;
						end
					end else begin
						timer <= timer - 12'h001;
					end
				end
				S_WAIT_WB: begin
					// Busy is not visible until after the confirm settles
					if (timer == 12'h000) begin
						timer <= ARRAY_T;
						if (jump_op) begin
							state <= S_READ;
						end else begin
							// Chip enable is released while the array read runs
							o_ce_n <= 1'b1;
							state  <= S_WAIT_RDY;
						end
					end else begin
						timer <= timer - 12'h001;
					end
				end
				S_WAIT_RDY: begin
					if (rb_sync) begin
						o_ce_n      <= 1'b0;
						page_loaded <= 1'b1;
						timer       <= 12'h000;
						state       <= S_READ;
					end else if (timer == 12'h000) begin
						// A part that overruns the array latency is reported, not waited on
						o_timeout <= 1'b1;
						state     <= S_FINISH;
					end else begin
						timer <= timer - 12'h001;
					end
				end
				S_READ: begin
					if (timer != 12'h000) begin
						timer <= timer - 12'h001;
					end else if (!o_read_strobe_n) begin
						o_read_strobe_n <= 1'b1;
						timer           <= extended_data_out ? RE_HIGH_ET : RE_HIGH_T;
					end else if (may_fall) begin
						// Capture lands CAP_DLY later; in EXTENDED_DATA_OUT mode that is past the next fall
						o_read_strobe_n <= 1'b0;
						cap_pipe[0]     <= 1'b1;
						column          <= column + 12'h001;
						falls_left      <= falls_left - 13'h0001;
						timer           <= extended_data_out ? RE_LOW_ET : RE_LOW_T;
					end else if (falls_left == 13'h0000 && cap_pipe == {CAP_DLY{1'b0}}) begin
						state <= S_FINISH;
					end
				end
				S_FINISH: begin
					o_ce_n          <= 1'b1;
					o_read_strobe_n <= 1'b1;
					o_busy          <= 1'b0;
					o_done          <= 1'b1;
					state           <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Read data buffer
	// ----------------------------------------
	// Falls are only issued while enough room is reserved for bytes in flight
	sync_fifo #(
		.WIDTH (`FIFO_WIDTH),
		.DEPTH (`FIFO_DEPTH),
		.AW    (5)
	) u_read_fifo (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.i_data    (io_sync),
		.i_valid   (cap_now),
		.o_ready   (fifo_in_ready),
		.o_data    (o_data),
		.o_valid   (o_data_valid),
		.i_ready   (i_data_ready),
		.o_count   (fifo_count)
	);

endmodule // nand_read_host

// ---- hw/sync_fifo.v ----
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps

module sync_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             i_clk_sys,
	input  wire             i_reset_n,
	input  wire [WIDTH-1:0] i_data,
	input  wire             i_valid,
	output wire             o_ready,
	output wire [WIDTH-1:0] o_data,
	output wire             o_valid,
	input  wire             i_ready,
	output wire [AW:0]      o_count
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;

	wire push = i_valid && o_ready;
	wire pop  = o_valid && i_ready;

	assign o_ready = (count != DEPTH[AW:0]);
	assign o_valid = (count != {(AW+1){1'b0}});
	assign o_data  = mem[rd_ptr];
	assign o_count = count;

	always @(posedge i_clk_sys) begin
		if (push)
			mem[wr_ptr] <= i_data;
	end

	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

endmodule // sync_fifo

// ---- include/nand_host_defs.vh ----
// Constants for the NAND page read host controller
`ifndef NAND_HOST_DEFS_VH
`define NAND_HOST_DEFS_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_READ_SETUP   8'h00
`define CMD_READ_CONFIRM 8'h30
`define CMD_JUMP_SETUP   8'h05
`define CMD_JUMP_CONFIRM 8'he0

// ----------------------------------------
// Address map and page layout
// ----------------------------------------
`define PAGE_MAIN_BYTES  13'h0800
`define PAGE_SPARE_BYTES 13'h0040
`define PAGE_BYTES       (`PAGE_MAIN_BYTES + `PAGE_SPARE_BYTES)
`define READ_ADDR_CYCLES 3'h5
`define JUMP_ADDR_CYCLES 3'h2
`define ROW_TOP_BIT_LSB  17
`define DENSITY_4GB      1'h1

// ----------------------------------------
// Timing, figures in ns (array read in us), counts in cycles
// ----------------------------------------
`define CLK_PERIOD_NS    10
`define WE_LOW_NS        20
`define WE_HIGH_NS       10
`define WB_DELAY_NS      100
`define RE_LOW_NS        30
`define RE_HIGH_NS       10
`define RE_LOW_EDO_NS    10
`define RE_HIGH_EDO_NS   10
`define READ_ACCESS_NS   20
`define ARRAY_READ_US    25
`define WE_LOW_CYC       ((`WE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WE_HIGH_CYC      ((`WE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WB_DELAY_CYC     ((`WB_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RE_LOW_CYC       ((`RE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RE_HIGH_CYC      ((`RE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RE_LOW_EDO_CYC   ((`RE_LOW_EDO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RE_HIGH_EDO_CYC  ((`RE_HIGH_EDO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_ACCESS_CYC  ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_STAGES      2
`define CAPTURE_DELAY    (`READ_ACCESS_CYC + `SYNC_STAGES)
`define ARRAY_READ_CYC   ((`ARRAY_READ_US * 1000) / `CLK_PERIOD_NS)

// ----------------------------------------
// Read data buffer
// ----------------------------------------
`define FIFO_WIDTH       8
`define FIFO_DEPTH       32

`endif
